//--- rtl/rttc_params.svh
// Constants of the time-trigger compare unit
`ifndef RTTC_PARAMS_SVH
`define RTTC_PARAMS_SVH

`define RTTC_CLK_PERIOD_NS 20
`define RTTC_NS_STEP (`RTTC_CLK_PERIOD_NS)
`define RTTC_NS_PER_SEC 32'h3b9a_ca00
`define RTTC_MAX_CHANNELS 2

`define RTTC_OFS_GEN_CFG 8'h00
`define RTTC_OFS_IRQ_EN 8'h04
`define RTTC_OFS_MASKED 8'h08
`define RTTC_OFS_RAW 8'h0c
`define RTTC_OFS_CLK_NS 8'h30
`define RTTC_OFS_CLK_SEC 8'h34
`define RTTC_OFS_TGT0_NS 8'h40
`define RTTC_OFS_TGT0_SEC 8'h44
`define RTTC_OFS_TGT1_NS 8'h48
`define RTTC_OFS_TGT1_SEC 8'h4c

`define RTTC_RST_WORD 32'h0000_0000
`define RTTC_RESP_OKAY 2'h0
`define RTTC_RESP_SLVERR 2'h2

`endif

//--- rtl/rttc_pkg.sv
// Types of the time-trigger compare unit
package rttc_pkg;
    typedef logic [31:0] rttc_word_t;
    typedef logic [63:0] rttc_time_t;
    typedef logic [1:0] rttc_resp_t;

    // Merge write data into a word under byte strobes
    function automatic rttc_word_t rttc_merge_f(input rttc_word_t old_w,
                                                input rttc_word_t new_w,
                                                input logic [3:0] strb);
        rttc_word_t res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction
endpackage

//--- rtl/rttc_reg_if.sv
// Register access carrier between bus slave and register file
`timescale 1ns/1ps
`default_nettype none
interface rttc_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_ok;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_ok;
    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                  output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

//--- rtl/rttc_axil_slave.sv
// AXI4-Lite slave front end, one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
module rttc_axil_slave
    import rttc_pkg::*;
(
    input wire logic clock_i,        // 50 MHz clock
    input wire logic sys_rst_i,      // Sync reset, high
    input wire logic [7:0] awaddr_i, // Write address
    input wire logic awvalid_i,      // Write address valid
    output logic awready_o,          // Write address ready
    input wire logic [31:0] wdata_i, // Write data
    input wire logic [3:0] wstrb_i,  // Byte strobes
    input wire logic wvalid_i,       // Write data valid
    output logic wready_o,           // Write data ready
    output logic [1:0] bresp_o,      // Write response
    output logic bvalid_o,           // Write response valid
    input wire logic bready_i,       // Write response ready
    input wire logic [7:0] araddr_i, // Read address
    input wire logic arvalid_i,      // Read address valid
    output logic arready_o,          // Read address ready
    output logic [31:0] rdata_o,     // Read data
    output logic [1:0] rresp_o,      // Read response
    output logic rvalid_o,           // Read valid
    input wire logic rready_i,       // Read ready
    rttc_reg_if.bus rif              // Register side
);
    `include "rttc_params.svh"

    logic aw_held_r, w_held_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;

    // Handshakes and the write strobe once both halves are held
    wire aw_take = awvalid_i && awready_o;
    wire w_take = wvalid_i && wready_o;
    wire ar_take = arvalid_i && arready_o;
    wire wr_fire = aw_held_r && w_held_r && !bvalid_o;

    // Next state of holds and valids, so the readies can leave a flop
    wire aw_held_nxt = (aw_take || aw_held_r) && !wr_fire;
    wire w_held_nxt = (w_take || w_held_r) && !wr_fire;
    wire bvalid_nxt = wr_fire || (bvalid_o && !bready_i);
    wire rvalid_nxt = ar_take || (rvalid_o && !rready_i);

    assign rif.wr_en = wr_fire;
    assign rif.wr_addr = aw_addr_r;
    assign rif.wr_data = w_data_r;
    assign rif.wr_strb = w_strb_r;
    assign rif.rd_addr = araddr_i;

    // Write channel capture and response
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= `RTTC_RST_WORD;
            w_strb_r <= 4'h0;
            bvalid_o <= 1'b0;
            bresp_o <= `RTTC_RESP_OKAY;
            awready_o <= 1'b1;
            wready_o <= 1'b1;
        end else begin
            awready_o <= !aw_held_nxt && !bvalid_nxt;
            wready_o <= !w_held_nxt && !bvalid_nxt;
            if (aw_take) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= awaddr_i;
            end
            if (w_take) begin
                w_held_r <= 1'b1;
                w_data_r <= wdata_i;
                w_strb_r <= wstrb_i;
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_o <= 1'b1;
                bresp_o <= rif.wr_ok ? `RTTC_RESP_OKAY : `RTTC_RESP_SLVERR;
            end else if (bvalid_o && bready_i) begin
                bvalid_o <= 1'b0;
            end
        end
    end

    // Read channel: data registered one cycle after address
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rvalid_o <= 1'b0;
            rdata_o <= `RTTC_RST_WORD;
            rresp_o <= `RTTC_RESP_OKAY;
            arready_o <= 1'b1;
        end else begin
            arready_o <= !rvalid_nxt;
            if (ar_take) begin
                rvalid_o <= 1'b1;
                rdata_o <= rif.rd_data;
                rresp_o <= rif.rd_ok ? `RTTC_RESP_OKAY : `RTTC_RESP_SLVERR;
            end else if (rvalid_o && rready_i) begin
                rvalid_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/rttc_cmp_chan.sv
// One trigger channel: reached-or-passed compare and first-hit pulse
`timescale 1ns/1ps
`default_nettype none
module rttc_cmp_chan
    import rttc_pkg::*;
(
    input wire logic clock_i,          // 50 MHz clock
    input wire logic sys_rst_i,        // Sync reset, high
    input wire rttc_time_t now_i,      // Running time {sec, ns}
    input wire rttc_time_t target_i,   // Target {sec, ns}
    output logic hit_o                 // One-cycle match pulse
);
    logic reached_r;

    // Seconds in the high half, so a plain compare orders whole times
    wire reached = (now_i >= target_i);

    // Pulse only on the cycle after the time first reaches the target
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            reached_r <= 1'b1;
            hit_o <= 1'b0;
        end else begin
            reached_r <= reached;
            hit_o <= reached && !reached_r;
        end
    end
endmodule
`default_nettype wire

//--- rtl/rttc_top.sv
// Time-trigger compare unit with running clock and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module rttc_top
    import rttc_pkg::*;
#(
    parameter int TRIG_CNT = 2 // Number of trigger channels, 0..2
) (
    input wire logic clock_i,        // 50 MHz clock
    input wire logic sys_rst_i,      // Sync reset, high
    input wire logic [7:0] awaddr_i, // Write address
    input wire logic awvalid_i,      // Write address valid
    output logic awready_o,          // Write address ready
    input wire logic [31:0] wdata_i, // Write data
    input wire logic [3:0] wstrb_i,  // Byte strobes
    input wire logic wvalid_i,       // Write data valid
    output logic wready_o,           // Write data ready
    output logic [1:0] bresp_o,      // Write response
    output logic bvalid_o,           // Write response valid
    input wire logic bready_i,       // Write response ready
    input wire logic [7:0] araddr_i, // Read address
    input wire logic arvalid_i,      // Read address valid
    output logic arready_o,          // Read address ready
    output logic [31:0] rdata_o,     // Read data
    output logic [1:0] rresp_o,      // Read response
    output logic rvalid_o,           // Read valid
    input wire logic rready_i,       // Read ready
    output logic [1:0] trig_pulse_o, // Trigger output pulses
    output logic irq_o               // Level interrupt
);
    `include "rttc_params.svh"

    localparam int NCH = `RTTC_MAX_CHANNELS;
    localparam logic [31:0] NS_STEP = 32'(`RTTC_NS_STEP);
    localparam logic [31:0] NS_WRAP = `RTTC_NS_PER_SEC - NS_STEP;

    // Refuse channel counts the logic cannot serve
    if (TRIG_CNT < 0 || TRIG_CNT > NCH) begin : g_bad_cnt
        $error("rttc_top: TRIG_CNT must be 0..2");
    end

    rttc_reg_if rif ();

    // Registers and running time
    logic [NCH-1:0] out_en_r;       // General configuration, output enables
    logic [NCH-1:0] irq_en_r;       // Interrupt enable
    logic [NCH-1:0] raw_r;          // Raw sticky flags
    logic [NCH-1:0] raw_nxt;
    logic [31:0] clk_ns_r;
    logic [31:0] clk_sec_r;
    logic [31:0] clk_ns_nxt;
    logic [31:0] clk_sec_nxt;
    rttc_word_t tgt_ns_r [NCH];
    rttc_word_t tgt_sec_r [NCH];
    logic [NCH-1:0] hit;
    logic [NCH-1:0] chan_on;

    // Bus slave
    rttc_axil_slave u_slave (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .awaddr_i(awaddr_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .bresp_o(bresp_o),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .araddr_i(araddr_i),
        .arvalid_i(arvalid_i),
        .arready_o(arready_o),
        .rdata_o(rdata_o),
        .rresp_o(rresp_o),
        .rvalid_o(rvalid_o),
        .rready_i(rready_i),
        .rif(rif)
    );

    // Write address decode
    wire wa_cfg = rif.wr_en && (rif.wr_addr == `RTTC_OFS_GEN_CFG);
    wire wa_ien = rif.wr_en && (rif.wr_addr == `RTTC_OFS_IRQ_EN);
    wire wa_raw = rif.wr_en && (rif.wr_addr == `RTTC_OFS_RAW);
    wire wa_cns = rif.wr_en && (rif.wr_addr == `RTTC_OFS_CLK_NS);
    wire wa_csec = rif.wr_en && (rif.wr_addr == `RTTC_OFS_CLK_SEC);
    wire [31:0] wmerged_cfg = rttc_merge_f(32'(out_en_r), rif.wr_data, rif.wr_strb);
    wire [31:0] wmerged_ien = rttc_merge_f(32'(irq_en_r), rif.wr_data, rif.wr_strb);
    wire [31:0] wmerged_ns = rttc_merge_f(clk_ns_r, rif.wr_data, rif.wr_strb);
    wire [31:0] wmerged_sec = rttc_merge_f(clk_sec_r, rif.wr_data, rif.wr_strb);
    wire [NCH-1:0] w1c = wa_raw ? (rif.wr_data[NCH-1:0] & {NCH{rif.wr_strb[0]}})
                                : {NCH{1'b0}};
    wire wa_tgt = rif.wr_en && (rif.wr_addr >= `RTTC_OFS_TGT0_NS)
                  && (rif.wr_addr <= `RTTC_OFS_TGT1_SEC) && (rif.wr_addr[1:0] == 2'h0);
    wire wa_tgt_ok = wa_tgt && (int'(rif.wr_addr[3]) < TRIG_CNT);
    assign rif.wr_ok = wa_cfg || wa_ien || wa_raw || wa_cns || wa_csec || wa_tgt_ok
                       || (rif.wr_addr == `RTTC_OFS_MASKED);

    // Read address decode and mux
    wire [7:0] ra = rif.rd_addr;
    wire ra_tgt = (ra >= `RTTC_OFS_TGT0_NS) && (ra <= `RTTC_OFS_TGT1_SEC)
                  && (ra[1:0] == 2'h0) && (int'(ra[3]) < TRIG_CNT);
    wire [31:0] rd_tgt = ra[2] ? tgt_sec_r[ra[3]] : tgt_ns_r[ra[3]];
    assign rif.rd_ok = ra_tgt || (ra == `RTTC_OFS_GEN_CFG) || (ra == `RTTC_OFS_IRQ_EN)
                       || (ra == `RTTC_OFS_MASKED) || (ra == `RTTC_OFS_RAW)
                       || (ra == `RTTC_OFS_CLK_NS) || (ra == `RTTC_OFS_CLK_SEC);
    assign rif.rd_data = ra_tgt ? rd_tgt
                       : (ra == `RTTC_OFS_GEN_CFG) ? 32'(out_en_r)
                       : (ra == `RTTC_OFS_IRQ_EN) ? 32'(irq_en_r)
                       : (ra == `RTTC_OFS_MASKED) ? 32'(raw_r & irq_en_r)
                       : (ra == `RTTC_OFS_RAW) ? 32'(raw_r)
                       : (ra == `RTTC_OFS_CLK_NS) ? clk_ns_r
                       : (ra == `RTTC_OFS_CLK_SEC) ? clk_sec_r
                       : 32'h0000_0000;

    // Running time: 20 ns per edge, carry into seconds at one second
    wire ns_wrap = (clk_ns_r >= NS_WRAP);
    assign clk_ns_nxt = wa_cns ? wmerged_ns
                      : ns_wrap ? (clk_ns_r - NS_WRAP) : (clk_ns_r + NS_STEP);
    assign clk_sec_nxt = wa_csec ? wmerged_sec
                       : ns_wrap ? (clk_sec_r + 32'h0000_0001) : clk_sec_r;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            clk_ns_r <= `RTTC_RST_WORD;
            clk_sec_r <= `RTTC_RST_WORD;
        end else begin
            clk_ns_r <= clk_ns_nxt;
            clk_sec_r <= clk_sec_nxt;
        end
    end

    // Per-channel targets and compare
    for (genvar c = 0; c < NCH; c++) begin : g_chan
        wire wa_ns = wa_tgt_ok && (int'(rif.wr_addr[3]) == c) && !rif.wr_addr[2];
        wire wa_sec = wa_tgt_ok && (int'(rif.wr_addr[3]) == c) && rif.wr_addr[2];
        logic hit_raw;
        assign chan_on[c] = (c < TRIG_CNT);

        // Software target words, zero after reset
        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                tgt_ns_r[c] <= `RTTC_RST_WORD;
                tgt_sec_r[c] <= `RTTC_RST_WORD;
            end else begin
                if (wa_ns) begin
                    tgt_ns_r[c] <= rttc_merge_f(tgt_ns_r[c], rif.wr_data, rif.wr_strb);
                end
                if (wa_sec) begin
                    tgt_sec_r[c] <= rttc_merge_f(tgt_sec_r[c], rif.wr_data, rif.wr_strb);
                end
            end
        end

        rttc_cmp_chan u_cmp (
            .clock_i(clock_i),
            .sys_rst_i(sys_rst_i),
            .now_i({clk_sec_r, clk_ns_r}),
            .target_i({tgt_sec_r[c], tgt_ns_r[c]}),
            .hit_o(hit_raw)
        );
        assign hit[c] = hit_raw && chan_on[c];

        // Set wins over write-one-clear; a match never clears
        assign raw_nxt[c] = hit[c] || (raw_r[c] && !w1c[c]);
    end

    // Control registers, raw flags, trigger pulses and interrupt
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            out_en_r <= {NCH{1'b0}};
            irq_en_r <= {NCH{1'b0}};
            raw_r <= {NCH{1'b0}};
            trig_pulse_o <= 2'h0;
            irq_o <= 1'b0;
        end else begin
            if (wa_cfg) begin
                out_en_r <= wmerged_cfg[NCH-1:0] & chan_on;
            end
            if (wa_ien) begin
                irq_en_r <= wmerged_ien[NCH-1:0] & chan_on;
            end
            raw_r <= raw_nxt;
            trig_pulse_o <= hit & out_en_r;
            irq_o <= |(raw_r & irq_en_r);
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    a_raw0_set: assert property (hit[0] |=> raw_r[0])
        else $error("channel 0 match did not set raw flag");
    a_raw1_set: assert property (hit[1] |=> raw_r[1])
        else $error("channel 1 match did not set raw flag");
    a_raw_sticky: assert property (raw_r[0] && !w1c[0] |=> raw_r[0])
        else $error("raw flag dropped without a clear");
    a_irq0_gate: assert property (hit[0] && !irq_en_r[0] && !wa_ien && !raw_r[1] && !hit[1]
                                  |=> ##1 irq_o == 1'b0)
        else $error("interrupt raised by disabled channel 0");
    a_irq1_gate: assert property (hit[1] && irq_en_r[1] ##1 irq_en_r[1] |=> irq_o)
        else $error("enabled channel 1 match raised no interrupt");
    a_trigger0_pulse_out_out: assert property (trig_pulse_o[0] == $past(hit[0] && out_en_r[0]))
        else $error("trigger 0 output disagrees with match and enable");
    a_trigger1_pulse_out_out: assert property (trig_pulse_o[1] |-> $past(hit[1] && out_en_r[1]))
        else $error("trigger 1 output without enabled match");
    a_absent_chan: assert property (TRIG_CNT < 2 |-> !hit[1] && !trig_pulse_o[1])
        else $error("absent channel 1 active");
    a_none_chan: assert property (TRIG_CNT < 1 |-> !hit[0] && !raw_r[0])
        else $error("absent channel 0 active");
    a_ns_step: assert property (!wa_cns && !wa_csec && !ns_wrap
                                |=> clk_ns_r == $past(clk_ns_r) + NS_STEP)
        else $error("nanoseconds did not advance by the step");
    a_hit_reached: assert property (hit[0] |-> $past({clk_sec_r, clk_ns_r})
                                    >= $past({tgt_sec_r[0], tgt_ns_r[0]}))
        else $error("match before the target time");
    a_pulse_single: assert property (trig_pulse_o[0] |=> !trig_pulse_o[0])
        else $error("trigger pulse longer than one cycle");
    a_tgt_write: assert property (wa_tgt_ok && !rif.wr_addr[3] && !rif.wr_addr[2]
                                  && rif.wr_strb == 4'hf |=> tgt_ns_r[0] == $past(rif.wr_data))
        else $error("target write not stored");

    c_trigger0_pulse_out: cover property (trig_pulse_o[0]);
    c_irq_both: cover property (raw_r == 2'h3 && irq_o);
    c_clear_race: cover property (hit[0] && w1c[0]);
endmodule
`default_nettype wire

//--- tb/rttc_top_tb.sv
// Self-checking bench for the time-trigger compare unit
`timescale 1ns/1ps
`default_nettype none
module rttc_top_tb;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
        logic [1:0] r;
    } rttc_row_t;

    logic clock_i;
    logic sys_rst_i;
    logic [7:0] awaddr_i;
    logic awvalid_i;
    logic awready_o;
    logic [31:0] wdata_i;
    logic [3:0] wstrb_i;
    logic wvalid_i;
    logic wready_o;
    logic [1:0] bresp_o;
    logic bvalid_o;
    logic bready_i;
    logic [7:0] araddr_i;
    logic arvalid_i;
    logic arready_o;
    logic [31:0] rdata_o;
    logic [1:0] rresp_o;
    logic rvalid_o;
    logic rready_i;
    logic [1:0] trig_pulse_o;
    logic irq_o;
    logic [31:0] q;
    logic [1:0] r;
    int miscompares = 0;
    int n_tests = 0;
    int pc [2] = '{0, 0};
    rttc_row_t rows [7];

    rttc_top #(.TRIG_CNT(2)) dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
        .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
        .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
        .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .trig_pulse_o(trig_pulse_o), .irq_o(irq_o)
    );

    // 50 MHz clock
    always #10 clock_i = ~clock_i;

    // Count trigger pulses per channel
    always @(posedge clock_i) begin
        if (trig_pulse_o[0] === 1'b1) pc[0] <= pc[0] + 1;
        if (trig_pulse_o[1] === 1'b1) pc[1] <= pc[1] + 1;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clock_i);
        miscompares++;
        wrap_up();
    end

    task automatic wrap_up();
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // One AXI4-Lite transfer; ready is sampled mid-cycle, released after the edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] qo, output logic [1:0] ro);
        logic done;
        logic ta;
        logic tw;
        logic tr;
        done = 1'b0;
        @(posedge clock_i);
        if (wr) begin
            awaddr_i <= a;
            wdata_i <= d;
            awvalid_i <= 1'b1;
            wvalid_i <= 1'b1;
            bready_i <= 1'b1;
        end else begin
            araddr_i <= a;
            arvalid_i <= 1'b1;
            rready_i <= 1'b1;
        end
        while (!done) begin
            @(negedge clock_i);
            ta = awvalid_i & awready_o;
            tw = wvalid_i & wready_o;
            tr = arvalid_i & arready_o;
            done = wr ? (bvalid_o & bready_i) : (rvalid_o & rready_i);
            qo = rdata_o;
            ro = wr ? bresp_o : rresp_o;
            @(posedge clock_i);
            if (ta) awvalid_i <= 1'b0;
            if (tw) wvalid_i <= 1'b0;
            if (tr) arvalid_i <= 1'b0;
            if (done) begin
                bready_i <= 1'b0;
                rready_i <= 1'b0;
            end
        end
    endtask

    task automatic wrc(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, q, r);
        chk("write response", 32'h0, {30'h0, r});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q, r);
        chk("read data", e, q);
        chk("read response", 32'h0, {30'h0, r});
    endtask

    // Wait for one new pulse on a channel, then see it is gone
    task automatic wait_hit(input int ch);
        int b;
        int k;
        b = pc[ch];
        k = 0;
        while (pc[ch] == b && k < 400) begin
            @(negedge clock_i);
            k++;
        end
        chk("pulse count", b + 1, pc[ch]);
        chk("pulse width", 32'h0, {31'h0, trig_pulse_o[ch]});
    endtask

    // Poll raw status until the given bits show
    task automatic poll(input logic [31:0] m);
        int k;
        k = 0;
        q = 32'h0;
        while ((q & m) == 32'h0 && k < 100) begin
            bus(1'b0, 8'h0c, 32'h0, q, r);
            k++;
        end
        chk("raw flag", m, q & m);
    endtask

    // Main sequence
    initial begin
        clock_i = 1'b0;
        sys_rst_i = 1'b1;
        awaddr_i = 8'h00;
        awvalid_i = 1'b0;
        wdata_i = 32'h0;
        wstrb_i = 4'hf;
        wvalid_i = 1'b0;
        bready_i = 1'b0;
        araddr_i = 8'h00;
        arvalid_i = 1'b0;
        rready_i = 1'b0;
        rows = '{'{8'h40, 32'ha5a5_0f0f, 32'ha5a5_0f0f, 2'h0},
                 '{8'h44, 32'h0000_0003, 32'h0000_0003, 2'h0},
                 '{8'h48, 32'hffff_ffff, 32'hffff_ffff, 2'h0},
                 '{8'h4c, 32'h8000_0001, 32'h8000_0001, 2'h0},
                 '{8'h00, 32'h0000_0003, 32'h0000_0003, 2'h0},
                 '{8'h08, 32'hffff_ffff, 32'h0000_0000, 2'h0},
                 '{8'h20, 32'hdead_beef, 32'h0000_0000, 2'h2}};
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(negedge clock_i);
        chk("irq after reset", 32'h0, {31'h0, irq_o});
        chk("pulses after reset", 32'h0, {30'h0, trig_pulse_o});
        // Reset value, write, read back per row
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0, q, r);
            chk("reset value", 32'h0, q);
            bus(1'b1, rows[i].a, rows[i].d, q, r);
            chk("write response", {30'h0, rows[i].r}, {30'h0, r});
            bus(1'b0, rows[i].a, 32'h0, q, r);
            chk("read back", rows[i].e, q);
            chk("read response", {30'h0, rows[i].r}, {30'h0, r});
        end
        // Channel 0 with output and interrupt enabled
        wrc(8'h00, 32'h1);
        wrc(8'h04, 32'h1);
        wrc(8'h40, 32'h0010_0000);
        wrc(8'h44, 32'h3);
        wrc(8'h30, 32'h000f_f830);
        wrc(8'h34, 32'h3);
        wait_hit(0);
        chk("channel 0 irq", 32'h1, {31'h0, irq_o});
        rdchk(8'h0c, 32'h1);
        rdchk(8'h08, 32'h1);
        chk("channel 1 quiet", 32'h0, pc[1]);
        // Fire again while the flag is still set
        wrc(8'h44, 32'h9);
        wrc(8'h44, 32'h3);
        wait_hit(0);
        rdchk(8'h0c, 32'h1);
        wrc(8'h0c, 32'h1);
        repeat (2) @(negedge clock_i);
        chk("irq after clear", 32'h0, {31'h0, irq_o});
        // Channel 1 across a seconds boundary, output and irq off
        wrc(8'h30, 32'h3b9a_c230);
        wrc(8'h34, 32'h1);
        wrc(8'h4c, 32'h2);
        wrc(8'h48, 32'h0);
        rdchk(8'h0c, 32'h0);
        poll(32'h2);
        chk("channel 1 no pulse", 32'h0, pc[1]);
        chk("channel 1 irq off", 32'h0, {31'h0, irq_o});
        wrc(8'h04, 32'h3);
        repeat (2) @(negedge clock_i);
        chk("channel 1 irq on", 32'h1, {31'h0, irq_o});
        wrc(8'h04, 32'h1);
        rdchk(8'h08, 32'h0);
        // Channel 1 output enabled, target lowered under the clock
        wrc(8'h00, 32'h3);
        wrc(8'h04, 32'h2);
        wrc(8'h4c, 32'h9);
        wrc(8'h4c, 32'h2);
        wait_hit(1);
        chk("channel 1 irq", 32'h1, {31'h0, irq_o});
        rdchk(8'h0c, 32'h2);
        // Channel 0 match with its interrupt off
        wrc(8'h0c, 32'h3);
        wrc(8'h40, 32'h0);
        wrc(8'h44, 32'h9);
        wrc(8'h44, 32'h2);
        wait_hit(0);
        chk("channel 0 irq off", 32'h0, {31'h0, irq_o});
        rdchk(8'h0c, 32'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
